// [inc/tmr_cfg.svh]
/*
  Constants of the temperature monitor register block: register addresses, field
  positions, reset values and conversion timing.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// Read and write addresses
`define TMR_A_LOCAL      8'h00
`define TMR_A_RHIGH      8'h01
`define TMR_A_STATUS     8'h02
`define TMR_A_CFG_RD     8'h03
`define TMR_A_RATE_RD    8'h04
`define TMR_A_LHL_RD     8'h05
`define TMR_A_LLL_RD     8'h06
`define TMR_A_RHL_RD     8'h07
`define TMR_A_RLL_RD     8'h08
`define TMR_A_CFG_WR     8'h09
`define TMR_A_RATE_WR    8'h0a
`define TMR_A_LHL_WR     8'h0b
`define TMR_A_LLL_WR     8'h0c
`define TMR_A_RHL_WR     8'h0d
`define TMR_A_RLL_WR     8'h0e
`define TMR_A_RLOW       8'h10
`define TMR_A_HYST       8'h21
`define TMR_A_LCRIT      8'h30
`define TMR_A_RCRIT      8'h31

// Configuration bit positions
`define TMR_CFG_MASK     7
`define TMR_CFG_STBY     6
`define TMR_CFG_PINSEL   5
`define TMR_CFG_RANGE    2

// Reset values
`define TMR_RST_PTR      8'h00
`define TMR_RST_VALUE    8'h00
`define TMR_RST_CFG      8'h00
`define TMR_RST_RATE     8'h08
`define TMR_RST_HIGH_LIM 8'h55
`define TMR_RST_LOW_LIM  8'h00
`define TMR_RST_HYST     8'h0a
`define TMR_RST_CRIT_LIM 8'h64
`define TMR_UNMAPPED     8'h00

// Result encoding
`define TMR_EXT_OFFSET   10'sd64
`define TMR_BIN_MAX      10'sd127
`define TMR_EXT_MAX      10'sd255
`define TMR_BIN_TOP      8'h7f
`define TMR_EXT_TOP      8'hff

// Conversion rate
`define TMR_RATE_MAX     4'ha
`define TMR_RATE_FAST    4'h8
`define TMR_AVG_LAST     4'hf
`define TMR_CLK_HZ       20000000
`define TMR_BASE_TIME_MS 16000
`define TMR_BASE_CYCLES  (`TMR_BASE_TIME_MS * (`TMR_CLK_HZ / 1000))

`endif

// [inc/tmr_pkg.sv]
/*
  Types of the temperature monitor register block.
  Assumes tmr_cfg.svh supplies the numeric constants.
*/
package tmr_pkg;

  typedef enum logic [1:0] {
    TMR_LNK_PTR   = 2'b00,
    TMR_LNK_WDATA = 2'b01,
    TMR_LNK_READ  = 2'b10
  } tmr_lnk_kind_t;

  typedef struct packed {
    tmr_lnk_kind_t kind;
    logic [7:0]    data;
  } tmr_lnk_req_t;

  typedef struct packed {
    logic signed [8:0]  local_deg;
    logic signed [10:0] remote_qdeg;
  } tmr_meas_t;

endpackage

// [logic/tmr_sync.sv]
/*
  Two flip-flop synchroniser for single-bit levels and toggles.
  Assumes the input is a level or a toggle from another domain.
*/
`timescale 1ns/1ps
module tmr_sync (
  // Destination clock
  input  logic clk,
  // Crossing signal
  input  logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule // tmr_sync

// [logic/tmr_crit_hyst.sv]
/*
  Critical limit comparator with hysteresis for one channel.
  Assumes value, limit and hysteresis share one data format.
*/
`timescale 1ns/1ps
module tmr_crit_hyst (
  // Clock and reset
  input  logic       core_clk,
  input  logic       rst_n,
  // Comparison inputs
  input  logic [7:0] value,
  input  logic [7:0] limit,
  input  logic [7:0] hyst,
  // Over-limit state
  output logic       over
);
  logic [8:0] release_lvl;

  assign release_lvl = {1'b0, limit} - {1'b0, hyst};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      over <= 1'b0;
    end else if (value > limit) begin
      over <= 1'b1;
    end else if (!release_lvl[8] && value <= release_lvl[7:0]) begin
      over <= 1'b0;
    end
  end

  a_hyst_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    (over && value <= limit && !release_lvl[8] && value > release_lvl[7:0]) |=> over)
    else $error("critical state released inside hysteresis band");
endmodule // tmr_crit_hyst

// [logic/tmr_regs.sv]
/*
  Register bank, conversion scheduler and limit comparison of a dual-channel
  temperature monitor, reached over a byte-level serial link on its own clock.
  Assumes the link party holds each request until link_ready takes it, and the
  measurement front end answers every conv_start with one meas_valid pulse.
*/
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_regs
  import tmr_pkg::*;
#(
  parameter logic [31:0] CONV_BASE_CYCLES = `TMR_BASE_CYCLES
) (
  // Core clock and reset
  input  logic         core_clk,
  input  logic         rst_n,
  // Link side
  input  logic         link_clk,
  input  logic         link_req,
  input  tmr_lnk_req_t link_in,
  output logic         link_ready,
  output logic [7:0]   link_rdata,
  output logic         link_rvalid,
  // Measurement front end
  output logic         conv_start,
  input  logic         meas_valid,
  input  tmr_meas_t    meas,
  // Output pins
  output logic         alert_pin_n,
  output logic         alert_pin_oe,
  output logic         critical_temp_out_n,
  output logic         critical_temp_oe,
  output logic [7:0]   status_flags
);

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain

  logic         link_rst_n;
  logic         req_tgl;
  logic         ack_tgl;
  logic         ack_sync;
  logic         ack_seen;
  tmr_lnk_req_t hold;
  logic [7:0]   rdata_hold;

  tmr_sync u_link_rst (.clk(link_clk), .d(rst_n), .q(link_rst_n));
  tmr_sync u_ack_sync (.clk(link_clk), .d(ack_tgl), .q(ack_sync));

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      link_ready  <= 1'b1;
      req_tgl     <= 1'b0;
      ack_seen    <= 1'b0;
      hold        <= '{kind: TMR_LNK_PTR, data: 8'h00};
      link_rdata  <= 8'h00;
      link_rvalid <= 1'b0;
    end else begin
      link_rvalid <= 1'b0;
      if (link_ready && link_req) begin
        hold       <= link_in;
        req_tgl    <= ~req_tgl;
        link_ready <= 1'b0;
      end else if (!link_ready && ack_sync != ack_seen) begin
        ack_seen    <= ack_sync;
        link_ready  <= 1'b1;
        link_rdata  <= rdata_hold;
        link_rvalid <= (hold.kind == TMR_LNK_READ);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request crossing into the core domain

  logic req_sync;
  logic req_seen;
  logic op_go;
  logic wr_go;
  logic rd_go;

  tmr_sync u_req_sync (.clk(core_clk), .d(req_tgl), .q(req_sync));

  assign op_go = req_sync ^ req_seen;
  assign wr_go = op_go && hold.kind == TMR_LNK_WDATA;
  assign rd_go = op_go && hold.kind == TMR_LNK_READ;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_seen <= 1'b0;
      ack_tgl  <= 1'b0;
    end else if (op_go) begin
      req_seen <= req_sync;
      ack_tgl  <= ~ack_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer and writable registers

  logic [7:0] ptr;
  logic [7:0] cfg;
  logic [7:0] rate;
  logic [7:0] lhl;
  logic [7:0] lll;
  logic [7:0] rhl;
  logic [7:0] rll;
  logic [7:0] hyst;
  logic [7:0] lcrit;
  logic [7:0] rcrit;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr <= `TMR_RST_PTR;
    end else if (op_go && hold.kind == TMR_LNK_PTR) begin
      ptr <= hold.data;
    end
  end

  // Limits are written only by the link, never rewritten on range change
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg   <= `TMR_RST_CFG;
      rate  <= `TMR_RST_RATE;
      lhl   <= `TMR_RST_HIGH_LIM;
      lll   <= `TMR_RST_LOW_LIM;
      rhl   <= `TMR_RST_HIGH_LIM;
      rll   <= `TMR_RST_LOW_LIM;
      hyst  <= `TMR_RST_HYST;
      lcrit <= `TMR_RST_CRIT_LIM;
      rcrit <= `TMR_RST_CRIT_LIM;
    end else if (wr_go) begin
      case (ptr)
        `TMR_A_CFG_WR:  cfg   <= hold.data;
        `TMR_A_RATE_WR: rate  <= hold.data;
        `TMR_A_LHL_WR:  lhl   <= hold.data;
        `TMR_A_LLL_WR:  lll   <= hold.data;
        `TMR_A_RHL_WR:  rhl   <= hold.data;
        `TMR_A_RLL_WR:  rll   <= hold.data;
        `TMR_A_HYST:    hyst  <= hold.data;
        `TMR_A_LCRIT:   lcrit <= hold.data;
        `TMR_A_RCRIT:   rcrit <= hold.data;
        default:        cfg   <= cfg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion scheduling and averaging

  logic        standby;
  logic        avg_on;
  logic [3:0]  code_eff;
  logic [31:0] period;
  logic [31:0] timer;
  logic        tick;
  logic [3:0]  avg_cnt;
  logic        avg_last;
  logic        conv_busy;
  logic signed [12:0] sum_l;
  logic signed [14:0] sum_r;
  logic signed [12:0] tot_l;
  logic signed [14:0] tot_r;
  logic signed [8:0]  res_l;
  logic signed [10:0] res_r;
  logic        res_valid;

  assign standby  = cfg[`TMR_CFG_STBY];
  assign code_eff = (rate[3:0] > `TMR_RATE_MAX) ? `TMR_RATE_MAX : rate[3:0];
  assign avg_on   = code_eff < `TMR_RATE_FAST;
  assign period   = CONV_BASE_CYCLES >> code_eff;
  assign tick     = !standby && timer == 32'h0000_0000;
  assign avg_last = !avg_on || avg_cnt == `TMR_AVG_LAST;
  assign tot_l    = sum_l + {{4{meas.local_deg[8]}}, meas.local_deg};
  assign tot_r    = sum_r + {{4{meas.remote_qdeg[10]}}, meas.remote_qdeg};

  always_ff @(posedge core_clk) begin
    if (!rst_n || standby) begin
      timer <= 32'h0000_0000;
    end else if (tick) begin
      timer <= period - 32'h0000_0001;
    end else begin
      timer <= timer - 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= tick || (!standby && meas_valid && !avg_last);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avg_cnt   <= 4'h0;
      sum_l     <= 13'sd0;
      sum_r     <= 15'sd0;
      res_l     <= 9'sd0;
      res_r     <= 11'sd0;
      res_valid <= 1'b0;
      conv_busy <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      if (conv_start) begin
        conv_busy <= 1'b1;
      end
      if (meas_valid && avg_last) begin
        res_l     <= avg_on ? tot_l[12:4] : meas.local_deg;
        res_r     <= avg_on ? tot_r[14:4] : meas.remote_qdeg;
        res_valid <= 1'b1;
        conv_busy <= 1'b0;
        avg_cnt   <= 4'h0;
        sum_l     <= 13'sd0;
        sum_r     <= 15'sd0;
      end else if (meas_valid) begin
        avg_cnt <= avg_cnt + 4'h1;
        sum_l   <= tot_l;
        sum_r   <= tot_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result encoding and value registers

  function automatic logic [7:0] enc_deg(input logic signed [8:0] t, input logic ext);
    logic signed [9:0] v;
    v = ext ? ({t[8], t} + `TMR_EXT_OFFSET) : {t[8], t};
    if (v < 10'sd0) begin
      enc_deg = 8'h00;
    end else if (v > (ext ? `TMR_EXT_MAX : `TMR_BIN_MAX)) begin
      enc_deg = ext ? `TMR_EXT_TOP : `TMR_BIN_TOP;
    end else begin
      enc_deg = v[7:0];
    end
  endfunction

  logic [7:0] local_value;
  logic [7:0] remote_high;
  logic [7:0] remote_low;
  logic       frozen;
  logic       ext_range;

  assign ext_range = cfg[`TMR_CFG_RANGE];

  // Only the converter path writes these; link writes never reach them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      local_value <= `TMR_RST_VALUE;
      remote_high <= `TMR_RST_VALUE;
      remote_low  <= `TMR_RST_VALUE;
    end else if (res_valid) begin
      local_value <= enc_deg(res_l, ext_range);
      if (!frozen) begin
        remote_high <= enc_deg(res_r[10:2], ext_range);
      end
      remote_low <= {res_r[1:0], 6'h00};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frozen <= 1'b0;
    end else if (rd_go && ptr == `TMR_A_RLOW) begin
      frozen <= 1'b1;
    end else if (rd_go && ptr == `TMR_A_RHIGH) begin
      frozen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Limit comparison and pins

  logic l_hi;
  logic l_lo;
  logic r_hi;
  logic r_lo;
  logic l_crit;
  logic r_crit;
  logic next_alert_n;

  // Codes compare directly, so limits follow whatever format the host wrote
  assign l_hi = local_value > lhl;
  assign l_lo = local_value <= lll;
  assign r_hi = remote_high > rhl;
  assign r_lo = remote_high <= rll;

  tmr_crit_hyst u_local_crit (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .value    (local_value),
    .limit    (lcrit),
    .hyst     (hyst),
    .over     (l_crit)
  );

  tmr_crit_hyst u_remote_crit (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .value    (remote_high),
    .limit    (rcrit),
    .hyst     (hyst),
    .over     (r_crit)
  );

  always_comb begin
    if (cfg[`TMR_CFG_PINSEL]) begin
      next_alert_n = ~(l_hi | r_hi);
    end else begin
      next_alert_n = ~((l_hi | l_lo | r_hi | r_lo) & ~cfg[`TMR_CFG_MASK]);
    end
  end

  // Pins follow register state every cycle, standby or not
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_pin_n         <= 1'b1;
      alert_pin_oe        <= 1'b0;
      critical_temp_out_n <= 1'b1;
      critical_temp_oe    <= 1'b0;
      status_flags        <= 8'h00;
    end else begin
      alert_pin_n         <= next_alert_n;
      alert_pin_oe        <= ~next_alert_n;
      critical_temp_out_n <= ~(l_crit | r_crit);
      critical_temp_oe    <= l_crit | r_crit;
      status_flags        <= {conv_busy, l_hi, l_lo, r_hi, r_lo, 1'b0, r_crit, l_crit};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_hold <= 8'h00;
    end else if (rd_go) begin
      case (ptr)
        `TMR_A_LOCAL:   rdata_hold <= local_value;
        `TMR_A_RHIGH:   rdata_hold <= remote_high;
        `TMR_A_STATUS:  rdata_hold <= status_flags;
        `TMR_A_CFG_RD:  rdata_hold <= cfg;
        `TMR_A_RATE_RD: rdata_hold <= rate;
        `TMR_A_LHL_RD:  rdata_hold <= lhl;
        `TMR_A_LLL_RD:  rdata_hold <= lll;
        `TMR_A_RHL_RD:  rdata_hold <= rhl;
        `TMR_A_RLL_RD:  rdata_hold <= rll;
        `TMR_A_RLOW:    rdata_hold <= remote_low;
        `TMR_A_HYST:    rdata_hold <= hyst;
        `TMR_A_LCRIT:   rdata_hold <= lcrit;
        `TMR_A_RCRIT:   rdata_hold <= rcrit;
        default:        rdata_hold <= `TMR_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_ptr_reset_zero: assert property (@(posedge core_clk)
    $rose(rst_n) |-> ptr == 8'h00)
    else $error("pointer not zero after reset");

  a_ptr_first_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
    (op_go && hold.kind == TMR_LNK_PTR) |=> ptr == $past(hold.data))
    else $error("pointer byte not stored");

  a_cfg_write_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_go && ptr == `TMR_A_CFG_WR) |=> cfg == $past(hold.data))
    else $error("configuration write lost");

  a_ro_value_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_go && !res_valid) |=> $stable(local_value) && $stable(remote_high))
    else $error("link write changed a value register");

  a_freeze_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    (frozen && !(rd_go && ptr == `TMR_A_RHIGH)) |=> $stable(remote_high))
    else $error("remote high byte changed while frozen");

  a_standby_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(standby) && standby |-> !conv_start)
    else $error("conversion started in standby");

  a_alarm_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cfg[`TMR_CFG_PINSEL] && cfg[`TMR_CFG_MASK]) |=> alert_pin_n && !alert_pin_oe)
    else $error("masked alarm pin driven");

  a_crit_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    (l_crit || r_crit) |=> !critical_temp_out_n && critical_temp_oe)
    else $error("critical pin not driven");

  a_binary_clamp: assert property (@(posedge core_clk) disable iff (!rst_n)
    (res_valid && !ext_range) |=> !local_value[7])
    else $error("binary result above 127");

  a_second_out_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg[`TMR_CFG_PINSEL] && (l_hi || r_hi)) |=> !alert_pin_n)
    else $error("second high-limit output not asserted");

  a_interval_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick |=> conv_start)
    else $error("interval start without conversion");

endmodule // tmr_regs

// [verif/tmr_host.sv]
/*
  Link host model: one request at a time, held until the block takes it.
  Assumes link_clk runs freely and the block answers within 20 link cycles.
*/
`timescale 1ns/1ps
module tmr_host
  import tmr_pkg::*;
(
  // Link clock
  input  logic         link_clk,
  // Request
  output logic         link_req,
  output tmr_lnk_req_t link_in,
  // Answer
  input  logic         link_ready,
  input  logic [7:0]   link_rdata,
  input  logic         link_rvalid
);
  initial begin
    link_req = 1'b0;
    link_in  = '{kind: TMR_LNK_READ, data: 8'h00};
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer; ok stays low if either wait runs out
  task automatic xfer(input tmr_lnk_kind_t k, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
    int n;
    ok = 1'b0;
    q  = 8'h00;
    @(posedge link_clk);
    link_req <= 1'b1;
    link_in  <= '{kind: k, data: d};
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge link_clk);
      ok = (link_ready === 1'b1);
    end
    link_req     <= 1'b0;
    link_in.data <= ~d;
    if (ok) begin
      ok = 1'b0;
      for (n = 0; n < 20 && !ok; n++) begin
        @(posedge link_clk);
        ok = (link_ready === 1'b1);
        if (link_rvalid === 1'b1) begin
          q = link_rdata;
        end
      end
    end
  endtask
endmodule // tmr_host

// [verif/test_tmr_regs.sv]
/*
  Testbench of tmr_regs: reset values, result formats, limits, pins, rates.
  Assumes tmr_host drives the link and the source answers each conv_start.
*/
`timescale 1ns/1ps
`include "tmr_cfg.svh"
`define CHK(act, exp) \
  begin \
    cmp_count++; \
    if ((act) !== (exp)) begin \
      error_cnt++; \
      $display("Error at %0t: got %h expected %h", $time, (act), (exp)); \
    end \
  end
module test_tmr_regs
  import tmr_pkg::*;
;
  localparam int          BASE     = 2048;
  localparam int          CT [6]   = '{-1, 0, 127, 128, -65, 192};
  localparam logic [15:0] RV [8]   = '{16'h1000, 16'h0100, 16'h0300, 16'h0408,
                                       16'h210a, 16'h0555, 16'h3064, 16'h3f00};
  logic         core_clk, rst_n, link_clk, link_req, link_ready, link_rvalid;
  logic         conv_start, meas_valid, alert_pin_n, alert_pin_oe;
  logic         critical_temp_out_n, critical_temp_oe;
  logic [7:0]   link_rdata, status_flags;
  tmr_lnk_req_t link_in;
  tmr_meas_t    meas;
  int           error_cnt = 0;
  int           cmp_count = 0;
  int           n_conv    = 0;

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  // Measurement source answers every start one cycle later
  always @(posedge core_clk) begin
    meas_valid <= conv_start;
    if (conv_start === 1'b1) begin
      n_conv <= n_conv + 1;
    end
  end

  tmr_regs #(.CONV_BASE_CYCLES(32'h800)) tmr_regs_i (
    .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .link_req(link_req),
    .link_in(link_in), .link_ready(link_ready), .link_rdata(link_rdata),
    .link_rvalid(link_rvalid), .conv_start(conv_start), .meas_valid(meas_valid),
    .meas(meas), .alert_pin_n(alert_pin_n), .alert_pin_oe(alert_pin_oe),
    .critical_temp_out_n(critical_temp_out_n), .critical_temp_oe(critical_temp_oe),
    .status_flags(status_flags));

  tmr_host tmr_host_i (
    .link_clk(link_clk), .link_req(link_req), .link_in(link_in),
    .link_ready(link_ready), .link_rdata(link_rdata), .link_rvalid(link_rvalid));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] enc(input int t, input int ext);
    int v;
    v = ext ? t + 64 : t;
    if (v < 0) v = 0;
    if (v > (ext ? 255 : 127)) v = ext ? 255 : 127;
    return v[7:0];
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic xf(input tmr_lnk_kind_t k, input logic [7:0] d, output logic [7:0] q);
    bit ok;
    tmr_host_i.xfer(k, d, q, ok);
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: link stall %h %h", $time, k, d);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xf(TMR_LNK_PTR, a, q);
    xf(TMR_LNK_WDATA, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xf(TMR_LNK_PTR, a, q);
    xf(TMR_LNK_READ, 8'h00, q);
  endtask

  task automatic set_meas(input int t, input int qd);
    @(posedge core_clk);
    meas <= '{local_deg: 9'(t), remote_qdeg: 11'(qd)};
    cyc(30);
  endtask

  task automatic gap(output int g);
    int n;
    for (n = 0; n < 200 && conv_start !== 1'b1; n++) @(posedge core_clk);
    @(posedge core_clk);
    g = 1;
    while (conv_start !== 1'b1 && g < 200) begin
      @(posedge core_clk);
      g++;
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #3ms;
    error_cnt++;
    $display("Error at %0t: watchdog %h %h", $time, cmp_count, 0);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int r, i, t, qd, c0, g, code;
    logic [7:0] q;
    rst_n <= 1'b0;
    meas  <= '0;
    void'($urandom(32'h171b));
    // Link domain reset is stretched by its own synchroniser
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge link_clk);
    xf(TMR_LNK_READ, 8'h00, q);
    `CHK(q, 8'h00)
    foreach (RV[k]) begin
      rd(RV[k][15:8], q);
      `CHK(q, RV[k][7:0])
    end
    $display("Test reset values done");

    for (r = 0; r < 2; r++) begin
      wr(`TMR_A_CFG_WR, r ? 8'h04 : 8'h00);
      for (i = 0; i < 12; i++) begin
        t  = (i < 6) ? CT[i] : int'($urandom_range(270)) - 70;
        qd = int'($urandom_range(1400)) - 400;
        set_meas(t, qd);
        rd(`TMR_A_LOCAL, q);
        `CHK(q, enc(t, r))
        xf(TMR_LNK_WDATA, ~q, q);
        xf(TMR_LNK_READ, 8'h00, q);
        `CHK(q, enc(t, r))
        rd(`TMR_A_RLOW, q);
        `CHK(q, {2'(qd), 6'h00})
        rd(`TMR_A_RHIGH, q);
        `CHK(q, enc(qd >>> 2, r))
      end
    end
    set_meas(20, 80);
    rd(`TMR_A_RLOW, q);
    set_meas(20, 200);
    rd(`TMR_A_RHIGH, q);
    `CHK(q, 8'h54)
    cyc(20);
    xf(TMR_LNK_READ, 8'h00, q);
    `CHK(q, 8'h72)
    $display("Test formats done");

    wr(`TMR_A_CFG_WR, 8'h00);
    set_meas(10, 80);
    `CHK({alert_pin_n, alert_pin_oe}, 2'b10)
    wr(`TMR_A_LLL_WR, 8'h0a);
    cyc(4);
    `CHK({alert_pin_n, alert_pin_oe, status_flags[5]}, 3'b011)
    wr(`TMR_A_CFG_WR, 8'h04);
    cyc(30);
    rd(`TMR_A_LLL_RD, q);
    `CHK(q, 8'h0a)
    `CHK({alert_pin_n, status_flags[5]}, 2'b10)
    wr(`TMR_A_LLL_WR, 8'h4a);
    cyc(4);
    `CHK(alert_pin_n, 1'b0)
    wr(`TMR_A_CFG_WR, 8'h84);
    cyc(4);
    `CHK(alert_pin_n, 1'b1)
    wr(`TMR_A_CFG_WR, 8'he4);
    cyc(20);
    c0 = n_conv;
    `CHK(alert_pin_n, 1'b1)
    wr(`TMR_A_LHL_WR, 8'h49);
    cyc(4);
    `CHK(alert_pin_n, 1'b0)
    wr(`TMR_A_LCRIT, 8'h48);
    cyc(4);
    `CHK({critical_temp_out_n, critical_temp_oe, status_flags[0]}, 3'b011)
    wr(`TMR_A_LCRIT, 8'h4b);
    cyc(4);
    `CHK(critical_temp_out_n, 1'b0)
    wr(`TMR_A_LCRIT, 8'h54);
    cyc(4);
    `CHK(critical_temp_out_n, 1'b1)
    rd(`TMR_A_CFG_RD, q);
    `CHK(q, 8'he4)
    `CHK(n_conv, c0)
    $display("Test limits and pins done");

    wr(`TMR_A_CFG_WR, 8'h04);
    for (code = 8; code < 13; code++) begin
      wr(`TMR_A_RATE_WR, 8'(code));
      rd(`TMR_A_RATE_RD, q);
      `CHK(q, 8'(code))
      gap(g);
      gap(g);
      `CHK(g, BASE >> ((code > 10) ? 10 : code))
    end
    // Averaging rate: sixteen starts per 64-cycle interval, ten intervals
    wr(`TMR_A_RATE_WR, 8'h05);
    cyc(100);
    c0 = n_conv;
    cyc(640);
    `CHK(n_conv - c0, 160)
    $display("Test rates done");
    end_of_test();
  end
endmodule // test_tmr_regs
